/* i2c_target_pkg.sv */
package i2c_target_pkg;

    // --------------------------------------------------------------
    // straps and target address
    // --------------------------------------------------------------
    localparam logic [4:0] NV_ADDR_UPPER_DEFAULT = 5'h19;
    localparam logic [1:0] ADDR_SEL_LOW = 2'h0;
    localparam logic [1:0] ADDR_SEL_MID = 2'h1;
    localparam logic [1:0] ADDR_SEL_HIGH = 2'h2;
    localparam logic [6:0] ADDR_DEFAULT_LOW = 7'h64;
    localparam logic [6:0] ADDR_DEFAULT_MID = 7'h65;
    localparam logic [6:0] ADDR_DEFAULT_HIGH = 7'h66;
    localparam logic PROTO_I2C = 1'b0;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // --------------------------------------------------------------
    // bus framing
    // --------------------------------------------------------------
    localparam int BUS_STANDARD_KHZ = 100;
    localparam int BUS_FAST_KHZ = 400;
    localparam logic [3:0] BIT_BYTE = 4'h8;
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic [1:0] PH_ADDR = 2'h0;
    localparam logic [1:0] PH_REGH = 2'h1;
    localparam logic [1:0] PH_REGL = 2'h2;
    localparam logic [1:0] PH_DATA = 2'h3;
    localparam logic RW_READ = 1'b1;
    localparam logic SDA_ACK = 1'b0;
    localparam logic [15:0] PTR_STEP = 16'h0001;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX = 3'h1,
        ST_RX_ACK = 3'h2,
        ST_TX = 3'h3,
        ST_TX_ACK = 3'h4,
        ST_WAIT = 3'h5
    } link_state_e;

endpackage

/* sync2.sv */
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_s;

    sync_s r;
    sync_s next_r;

    always_comb begin
        next_r.s1 = d_i;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q_o = r.s2;
endmodule // sync2

/* i2c_register_access_target.sv */
`timescale 1ns/10ps
module i2c_register_access_target (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic clk_link_i,
    input wire logic power_down_n_pin_i,
    input wire logic protocol_select_strap_i,
    input wire logic rom_page_strap_low_i,
    input wire logic rom_page_strap_high_i,
    input wire logic [1:0] address_select_pin_i,
    input wire logic [4:0] nv_addr_upper_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic [15:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i,
    output logic i2c_mode_o,
    output logic [1:0] rom_page_o,
    output logic [6:0] target_addr_o
);
    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        logic [1:0] settle;
        logic captured;
        logic i2c_mode;
        logic [1:0] rom_page;
        logic [6:0] taddr;
        logic cfg_valid;
        logic req_seen;
        logic rd_pend;
        logic ack_tgl;
        logic [7:0] rdata;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sys_s;

    typedef struct packed {
        i2c_target_pkg::link_state_e st;
        logic [1:0] phase;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] txbyte;
        logic rw;
        logic [15:0] ptr;
        logic [15:0] raddr;
        logic [7:0] wdata;
        logic rwe;
        logic req_tgl;
        logic ack_seen;
        logic scl_d;
        logic sda_d;
        logic sda_oe;
    } link_s;

    sys_s s;
    sys_s next_s;
    link_s l;
    link_s next_l;
    logic pd_s, proto_s, page_hi_s, page_lo_s;
    logic [1:0] sel_s;
    logic req_s;
    logic scl_s, sda_s, cfg_s, ack_s;
    logic link_nrst;
    logic req_edge;
    logic scl_rise, scl_fall, start_c, stop_c, rx_done;
    logic [1:0] sel_lsb;

    // --------------------------------------------------------------
    // crossings: pins and strobes pass two flops before use
    // --------------------------------------------------------------
    sync2 #(.W(6)) u_sync_pins (
        .clk_i(clk_sys_i),
        .nrst_i(nrst_i),
        .d_i({power_down_n_pin_i, protocol_select_strap_i, rom_page_strap_high_i,
              rom_page_strap_low_i, address_select_pin_i}),
        .q_o({pd_s, proto_s, page_hi_s, page_lo_s, sel_s})
    );

    sync2 #(.W(1)) u_sync_req (
        .clk_i(clk_sys_i),
        .nrst_i(nrst_i),
        .d_i(l.req_tgl),
        .q_o(req_s)
    );

    // link reset asserts at once and releases on the link clock
    sync2 #(.W(1)) u_sync_rst (
        .clk_i(clk_link_i),
        .nrst_i(nrst_i),
        .d_i(1'b1),
        .q_o(link_nrst)
    );

    sync2 #(.W(4)) u_sync_link (
        .clk_i(clk_link_i),
        .nrst_i(link_nrst),
        .d_i({scl_i, sda_i, s.cfg_valid, s.ack_tgl}),
        .q_o({scl_s, sda_s, cfg_s, ack_s})
    );

    // --------------------------------------------------------------
    // system side: straps and register port
    // --------------------------------------------------------------
    // an illegal pin code is treated as the high level
    assign sel_lsb = (sel_s == i2c_target_pkg::ADDR_SEL_LOW || sel_s == i2c_target_pkg::ADDR_SEL_MID) ?
                     sel_s : i2c_target_pkg::ADDR_SEL_HIGH;
    assign req_edge = req_s ^ s.req_seen;

    always_comb begin
        next_s = s;
        next_s.wr = 1'b0;
        next_s.rd = 1'b0;
        // power-down drops the interface; release reruns the strap capture
        if (!pd_s) begin
            next_s.settle = 2'h0;
            next_s.captured = 1'b0;
        end else if (!s.captured) begin
            if (s.settle == i2c_target_pkg::STRAP_SETTLE) begin
                next_s.captured = 1'b1;
                next_s.i2c_mode = (proto_s == i2c_target_pkg::PROTO_I2C);
                next_s.rom_page = {page_hi_s, page_lo_s};
                next_s.taddr = {nv_addr_upper_i, sel_lsb};
            end else begin
                next_s.settle = s.settle + 2'h1;
            end
        end
        next_s.cfg_valid = pd_s & s.captured & s.i2c_mode;
        // link request fields are stable from the toggle until our answer
        if (req_edge) begin
            next_s.req_seen = req_s;
            next_s.addr = l.raddr;
            next_s.wdata = l.wdata;
            if (l.rwe) begin
                next_s.wr = 1'b1;
                next_s.ack_tgl = ~s.ack_tgl;
            end else begin
                next_s.rd = 1'b1;
                next_s.rd_pend = 1'b1;
            end
        end
        if (s.rd_pend) begin
            next_s.rdata = reg_rdata_i;
            next_s.rd_pend = 1'b0;
            next_s.ack_tgl = ~s.ack_tgl;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // --------------------------------------------------------------
    // link side: bit engine on the oversampling link clock
    // --------------------------------------------------------------
    assign scl_rise = scl_s & ~l.scl_d;
    assign scl_fall = ~scl_s & l.scl_d;
    assign start_c = scl_s & l.scl_d & l.sda_d & ~sda_s;
    assign stop_c = scl_s & l.scl_d & ~l.sda_d & sda_s;
    assign rx_done = cfg_s & ~start_c & ~stop_c & (l.st == i2c_target_pkg::ST_RX) & scl_fall &
                     (l.bitcnt == i2c_target_pkg::BIT_BYTE);

    always_comb begin
        next_l = l;
        next_l.scl_d = scl_s;
        next_l.sda_d = sda_s;
        if (ack_s != l.ack_seen) begin
            next_l.ack_seen = ack_s;
            next_l.txbyte = s.rdata;
        end
        if (!cfg_s || stop_c) begin
            next_l.st = i2c_target_pkg::ST_IDLE;
            next_l.sda_oe = 1'b0;
        end else if (start_c) begin
            // a repeated start keeps the register pointer
            next_l.st = i2c_target_pkg::ST_RX;
            next_l.phase = i2c_target_pkg::PH_ADDR;
            next_l.bitcnt = 4'h0;
            next_l.sda_oe = 1'b0;
        end else begin
            unique case (l.st)
                i2c_target_pkg::ST_IDLE, i2c_target_pkg::ST_WAIT: begin
                end
                i2c_target_pkg::ST_RX: begin
                    if (scl_rise) begin
                        next_l.shreg = {l.shreg[6:0], sda_s};
                        next_l.bitcnt = l.bitcnt + 4'h1;
                    end else if (rx_done) begin
                        next_l.bitcnt = 4'h0;
                        next_l.st = i2c_target_pkg::ST_RX_ACK;
                        next_l.sda_oe = 1'b1;
                        unique case (l.phase)
                            i2c_target_pkg::PH_ADDR: begin
                                next_l.rw = l.shreg[0];
                                if (l.shreg[7:1] != s.taddr) begin
                                    next_l.st = i2c_target_pkg::ST_WAIT;
                                    next_l.sda_oe = 1'b0;
                                end
                            end
                            i2c_target_pkg::PH_REGH: begin
                                next_l.ptr[15:8] = l.shreg;
                            end
                            i2c_target_pkg::PH_REGL: begin
                                // prefetch so a read never waits on the crossing
                                next_l.ptr[7:0] = l.shreg;
                                next_l.raddr = {l.ptr[15:8], l.shreg};
                                next_l.rwe = 1'b0;
                                next_l.req_tgl = ~l.req_tgl;
                            end
                            i2c_target_pkg::PH_DATA: begin
                                next_l.raddr = l.ptr;
                                next_l.wdata = l.shreg;
                                next_l.rwe = 1'b1;
                                next_l.req_tgl = ~l.req_tgl;
                            end
                        endcase
                    end
                end
                i2c_target_pkg::ST_RX_ACK: begin
                    if (scl_fall) begin
                        next_l.sda_oe = 1'b0;
                        if (l.phase == i2c_target_pkg::PH_ADDR && l.rw == i2c_target_pkg::RW_READ) begin
                            next_l.st = i2c_target_pkg::ST_TX;
                            next_l.shreg = l.txbyte;
                            next_l.sda_oe = ~l.txbyte[7];
                            next_l.bitcnt = i2c_target_pkg::BIT_FIRST;
                            next_l.raddr = l.ptr + i2c_target_pkg::PTR_STEP;
                            next_l.rwe = 1'b0;
                            next_l.req_tgl = ~l.req_tgl;
                        end else begin
                            next_l.st = i2c_target_pkg::ST_RX;
                            if (l.phase == i2c_target_pkg::PH_DATA) begin
                                next_l.ptr = l.ptr + i2c_target_pkg::PTR_STEP;
                            end else begin
                                next_l.phase = l.phase + 2'h1;
                            end
                        end
                    end
                end
                i2c_target_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (l.bitcnt == i2c_target_pkg::BIT_BYTE) begin
                            next_l.sda_oe = 1'b0;
                            next_l.st = i2c_target_pkg::ST_TX_ACK;
                        end else begin
                            next_l.sda_oe = ~l.shreg[6];
                            next_l.shreg = {l.shreg[6:0], 1'b0};
                            next_l.bitcnt = l.bitcnt + 4'h1;
                        end
                    end
                end
                i2c_target_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        if (sda_s == i2c_target_pkg::SDA_ACK) begin
                            next_l.ptr = l.ptr + i2c_target_pkg::PTR_STEP;
                            next_l.st = i2c_target_pkg::ST_RX_ACK;
                        end else begin
                            next_l.st = i2c_target_pkg::ST_WAIT;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_link_i or negedge link_nrst) begin
        if (!link_nrst) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign sda_o = 1'b0;
    assign sda_oe_o = l.sda_oe;
    assign reg_addr_o = s.addr;
    assign reg_wdata_o = s.wdata;
    assign reg_wr_o = s.wr;
    assign reg_rd_o = s.rd;
    assign i2c_mode_o = s.i2c_mode;
    assign rom_page_o = s.rom_page;
    assign target_addr_o = s.taddr;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    addr_low_map_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(s.captured) && $past(nv_addr_upper_i) == i2c_target_pkg::NV_ADDR_UPPER_DEFAULT &&
        $past(sel_s) == i2c_target_pkg::ADDR_SEL_LOW |-> s.taddr == i2c_target_pkg::ADDR_DEFAULT_LOW)
        else $error("default low pin address wrong");
    addr_high_map_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(s.captured) && $past(nv_addr_upper_i) == i2c_target_pkg::NV_ADDR_UPPER_DEFAULT &&
        $past(sel_s) == i2c_target_pkg::ADDR_SEL_HIGH |-> s.taddr == i2c_target_pkg::ADDR_DEFAULT_HIGH)
        else $error("default high pin address wrong");
    addr_upper_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(s.captured) |-> s.taddr[6:2] == $past(nv_addr_upper_i))
        else $error("upper address bits not from nonvolatile value");
    page_strap_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(s.captured) |-> s.rom_page == $past({page_hi_s, page_lo_s}))
        else $error("settings page not from straps");
    mode_strap_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(s.captured) |-> s.i2c_mode == ($past(proto_s) == i2c_target_pkg::PROTO_I2C))
        else $error("mode not from protocol strap");
    power_down_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !pd_s |=> !s.cfg_valid ##1 !s.cfg_valid)
        else $error("interface enabled during power-down");
    write_strobe_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        req_edge && l.rwe |=> reg_wr_o && !reg_rd_o && reg_addr_o == $past(l.raddr))
        else $error("write request not strobed");
    read_answer_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s.rd |=> s.ack_tgl != $past(s.ack_tgl) && s.rdata == $past(reg_rdata_i))
        else $error("read answer missing");
    nomatch_quiet_a: assert property (@(posedge clk_link_i) disable iff (!link_nrst)
        rx_done && l.phase == i2c_target_pkg::PH_ADDR && l.shreg[7:1] != s.taddr
        |=> l.st == i2c_target_pkg::ST_WAIT && !l.sda_oe)
        else $error("foreign address acknowledged");
    data_write_a: assert property (@(posedge clk_link_i) disable iff (!link_nrst)
        rx_done && l.phase == i2c_target_pkg::PH_DATA
        |=> l.rwe && l.raddr == $past(l.ptr) && l.req_tgl != $past(l.req_tgl) && l.sda_oe)
        else $error("data byte not issued as write");
    reg_addr_a: assert property (@(posedge clk_link_i) disable iff (!link_nrst)
        rx_done && l.phase == i2c_target_pkg::PH_REGL |=> l.raddr == {$past(l.ptr[15:8]), $past(l.shreg)})
        else $error("register address not assembled");
    stop_release_a: assert property (@(posedge clk_link_i) disable iff (!link_nrst)
        stop_c && cfg_s |=> l.st == i2c_target_pkg::ST_IDLE && !l.sda_oe)
        else $error("stop did not release bus");

    write_seen_c: cover property (@(posedge clk_link_i) disable iff (!link_nrst)
        rx_done && l.phase == i2c_target_pkg::PH_DATA);
    read_seen_c: cover property (@(posedge clk_link_i) disable iff (!link_nrst)
        l.st == i2c_target_pkg::ST_TX_ACK && scl_rise);
    restart_c: cover property (@(posedge clk_link_i) disable iff (!link_nrst)
        start_c && cfg_s && l.st != i2c_target_pkg::ST_IDLE);
    nomatch_c: cover property (@(posedge clk_link_i) disable iff (!link_nrst)
        rx_done && l.phase == i2c_target_pkg::PH_ADDR && l.shreg[7:1] != s.taddr);
endmodule // i2c_register_access_target

/* i2c_host_model.sv */
`timescale 1ns/10ps
module i2c_host_model #(
    parameter int Q = 6
) (
    input wire logic clk_link_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_pull_o
);
    // ------------------------------------------------------------
    // bus phases, one quarter bit is Q link cycles
    // ------------------------------------------------------------
    // scl idles high and stands still between frames
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    // slow quarters keep every scl phase well clear of the target's sampler
    task automatic q();
        repeat (Q) @(posedge clk_link_i);
    endtask

    task automatic bus_start();
        sda_pull_o <= 1'b0;
        q();
        scl_o <= 1'b1;
        q();
        sda_pull_o <= 1'b1;
        q();
        scl_o <= 1'b0;
        q();
    endtask

    task automatic bus_stop();
        sda_pull_o <= 1'b1;
        q();
        scl_o <= 1'b1;
        q();
        sda_pull_o <= 1'b0;
        q();
    endtask

    task automatic xfer(input logic b, output logic r);
        sda_pull_o <= ~b;
        q();
        scl_o <= 1'b1;
        q();
        r = sda_i;
        q();
        scl_o <= 1'b0;
        q();
    endtask

    task automatic put_byte(input logic [7:0] d, output logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(d[i], r);
        xfer(1'b1, nack);
    endtask

    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        xfer(last, r);
    endtask
endmodule // i2c_host_model

/* tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    logic clk_sys_i, clk_link_i, nrst_i, power_down_n_pin_i, protocol_select_strap_i;
    logic rom_page_strap_low_i, rom_page_strap_high_i, scl, sda_pull, sda_w, sda_o, sda_oe_o;
    logic [1:0] address_select_pin_i;
    logic [4:0] nv_addr_upper_i;
    logic [15:0] reg_addr_o;
    logic [7:0] reg_wdata_o, reg_rdata_i;
    logic reg_wr_o, reg_rd_o, i2c_mode_o;
    logic [1:0] rom_page_o;
    logic [6:0] target_addr_o, own;
    logic [31:0] seed = 32'h0000_0046;
    logic [23:0] exp_q[$];
    int n_errors = 0;
    int checked = 0;

    // open drain bus with pull-up
    assign sda_w = ~sda_pull & (sda_oe_o ? sda_o : 1'b1);
    assign reg_rdata_i = reg_addr_o[15:8] ^ reg_addr_o[7:0] ^ 8'ha5;

    i2c_register_access_target i2c_register_access_target_i (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .clk_link_i(clk_link_i),
        .power_down_n_pin_i(power_down_n_pin_i), .protocol_select_strap_i(protocol_select_strap_i),
        .rom_page_strap_low_i(rom_page_strap_low_i), .rom_page_strap_high_i(rom_page_strap_high_i),
        .address_select_pin_i(address_select_pin_i), .nv_addr_upper_i(nv_addr_upper_i),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o),
        .reg_rdata_i(reg_rdata_i), .i2c_mode_o(i2c_mode_o), .rom_page_o(rom_page_o),
        .target_addr_o(target_addr_o));
    i2c_host_model i2c_host_model_i (.clk_link_i(clk_link_i), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(sda_pull));

    // ------------------------------------------------------------
    // clocks, checks and verdict
    // ------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        clk_link_i = 1'b0;
        #37;
        forever #80 clk_link_i = ~clk_link_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t value got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_wr(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t register write got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // each register write strobe consumes the oldest expectation; the falling edge keeps clear of the launch edge
    always @(negedge clk_sys_i) begin
        if (reg_wr_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("[ERR] %0t unexpected register write", $time);
            end else chk_wr({reg_addr_o, reg_wdata_o}, exp_q.pop_front());
        end
    end

    initial begin
        repeat (95000) @(posedge clk_sys_i);
        n_errors++;
        $display("[ERR] %0t run hung", $time);
        end_of_test();
    end

    // ------------------------------------------------------------
    // transactions
    // ------------------------------------------------------------
    task automatic configure(input logic [1:0] sel, input logic [4:0] nv, input logic proto);
        seed = xs(seed);
        @(posedge clk_sys_i);
        power_down_n_pin_i <= 1'b0;
        address_select_pin_i <= sel;
        nv_addr_upper_i <= nv;
        protocol_select_strap_i <= proto;
        rom_page_strap_low_i <= seed[0];
        rom_page_strap_high_i <= seed[1];
        repeat (20) @(posedge clk_sys_i);
        power_down_n_pin_i <= 1'b1;
        // straps are only re-sampled once power-down lifts
        repeat (200) @(posedge clk_sys_i);
        own = {nv, (sel == 2'h3) ? 2'h2 : sel};
        chk_val(16'(i2c_mode_o), 16'(proto == i2c_target_pkg::PROTO_I2C));
        if (proto == i2c_target_pkg::PROTO_I2C) begin
            chk_val(16'(target_addr_o), 16'(own));
            chk_val(16'(rom_page_o), 16'(seed[1:0]));
        end
    endtask

    task automatic put(input logic [7:0] b, input logic ok);
        logic nk;
        i2c_host_model_i.put_byte(b, nk);
        chk_val(16'(nk), 16'(!ok));
    endtask

    task automatic wr_xact(input logic [6:0] a, input logic ok, input int n);
        logic [15:0] r;
        logic [7:0] d;
        seed = xs(seed);
        r = seed[15:0];
        i2c_host_model_i.bus_start();
        put({a, 1'b0}, ok);
        put(r[15:8], ok);
        put(r[7:0], ok);
        for (int i = 0; i < n; i++) begin
            seed = xs(seed);
            d = seed[7:0];
            if (ok) exp_q.push_back({r + 16'(i), d});
            put(d, ok);
        end
        i2c_host_model_i.bus_stop();
        repeat (20) @(posedge clk_sys_i);
    endtask

    task automatic rd_xact(input logic [6:0] a, input int n);
        logic [15:0] r;
        logic [15:0] p;
        logic [7:0] d;
        seed = xs(seed);
        r = seed[15:0];
        i2c_host_model_i.bus_start();
        put({a, 1'b0}, 1'b1);
        put(r[15:8], 1'b1);
        put(r[7:0], 1'b1);
        i2c_host_model_i.bus_start();
        put({a, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            i2c_host_model_i.get_byte(i == n - 1, d);
            // the pointer carries into the high byte, so the whole address steps
            p = r + 16'(i);
            chk_val(16'(d), 16'(p[15:8] ^ p[7:0] ^ 8'ha5));
        end
        i2c_host_model_i.bus_stop();
        repeat (20) @(posedge clk_sys_i);
    endtask

    task automatic probe(input logic [6:0] a, input logic ok);
        i2c_host_model_i.bus_start();
        put({a, 1'b0}, ok);
        i2c_host_model_i.bus_stop();
    endtask

    initial begin
        logic [6:0] tab [4];
        tab = '{7'h64, 7'h65, 7'h66, 7'h66};
        nrst_i = 1'b0;
        power_down_n_pin_i = 1'b1;
        protocol_select_strap_i = 1'b0;
        rom_page_strap_low_i = 1'b0;
        rom_page_strap_high_i = 1'b0;
        address_select_pin_i = 2'h0;
        nv_addr_upper_i = i2c_target_pkg::NV_ADDR_UPPER_DEFAULT;
        repeat (6) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (100) @(posedge clk_sys_i);
        for (int s = 3; s >= 0; s--) begin
            configure(2'(s), i2c_target_pkg::NV_ADDR_UPPER_DEFAULT, 1'b0);
            chk_val(16'(target_addr_o), 16'(tab[s]));
            probe(tab[s], 1'b1);
        end
        wr_xact(7'h64, 1'b1, 1);
        rd_xact(7'h64, 1);
        wr_xact(7'h64, 1'b1, 3);
        rd_xact(7'h64, 3);
        wr_xact(7'h65, 1'b0, 1);
        @(posedge clk_sys_i);
        power_down_n_pin_i <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        probe(7'h64, 1'b0);
        configure(2'h1, 5'h0a, 1'b0);
        wr_xact(own, 1'b1, 1);
        configure(2'h0, i2c_target_pkg::NV_ADDR_UPPER_DEFAULT, 1'b1);
        probe(7'h64, 1'b0);
        repeat (50) @(posedge clk_sys_i);
        chk_val(16'(exp_q.size()), 16'h0000);
        end_of_test();
    end
endmodule // tb_top
